/* File: shared/flash_prog_params.svh */
`ifndef FLASH_PROG_PARAMS_SVH
`define FLASH_PROG_PARAMS_SVH

// phase codes carried on the 4-bit phase field
`define PHASE_COMMAND     4'h0
`define PHASE_ADDR_BYTE0  4'h1
`define PHASE_ADDR_BYTE1  4'h2
`define PHASE_ADDR_BYTE2  4'h3
`define PHASE_ADDR_BYTE3  4'h4
`define PHASE_DATA        4'h5

// command opcodes (arbitrary encodings)
`define OP_PAGE_WRITE     16'h0001
`define OP_PAGE_WRITE_LK  16'h0002
`define OP_ERASE_WRITE    16'h0003
`define OP_ERASE_WRITE_LK 16'h0004
`define OP_FULL_ERASE     16'h0005
`define OP_SET_LOCK       16'h0006
`define OP_CLEAR_LOCK     16'h0007
`define OP_GET_LOCK       16'h0008
`define OP_SET_FUSE       16'h0009
`define OP_CLEAR_FUSE     16'h000a
`define OP_GET_FUSE       16'h000b
`define OP_SET_SECURITY   16'h000c
`define OP_SELECT_CTRL    16'h000d
`define OP_MEMORY_WRITE   16'h000e
`define OP_GET_VERSION    16'h000f

// version identifier, value is arbitrary
`define PROG_VERSION      16'h0100

`define CTRL_RESET        1'b0
`define ADDR_STEP         32'h0000_0004
`define ADDR_RESET        32'h0000_0000
`define DATA_ZERO         16'h0000

`endif

/* File: shared/flash_prog_pkg.sv */
package flash_prog_pkg;

  typedef struct packed
  {
    logic        valid;
    logic [3:0]  phase;
    logic [15:0] data;
  } prog_word_s;

  typedef struct packed
  {
    logic        valid;
    logic        sel;
    logic [15:0] opcode;
    logic [15:0] data;
  } ctrl_cmd_s;

  typedef struct packed
  {
    logic        valid;
    logic [31:0] addr;
    logic [15:0] data;
  } mem_write_s;

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_SELECT,
    ST_MEMWRITE,
    ST_VERSION
  } cmd_state_e;

endpackage

/* File: verilog/flash_prog_cmd_ext.sv */
`timescale 1ns/1ps
`include "flash_prog_params.svh"
// Function
// - page write, erase, lock and fuse commands go to the selected controller.
// - after reset the first flash controller is selected.
// - select command then one data word; 0 picks first, 1 second.
// - memory write reaches any address using a 32-bit target address.
// - chained data words stored, address advancing after each word.
// - get-version followed by one data transfer returning the version.
// - serial variant carries traffic through the test access port.
// - run from RC oscillator when main clock grounded, else 32 kHz-50 MHz.
module flash_prog_cmd_ext
(
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire flash_prog_pkg::prog_word_s par_word_in,
  input  wire flash_prog_pkg::prog_word_s jtag_word_in,
  input  wire logic                     test_select_in,
  input  wire logic                     prog_enable_in_a,
  input  wire logic                     prog_enable_in_b,
  input  wire logic                     main_clock_present_in,
  output flash_prog_pkg::ctrl_cmd_s     ctrl_cmd_out,
  output flash_prog_pkg::mem_write_s    mem_write_out,
  output logic                          rd_valid_out,
  output logic [15:0]                   rd_data_out,
  output logic                          serial_mode_out,
  output logic                          use_rc_osc_out
);
  import flash_prog_pkg::*;

  logic [2:0]  pins_meta;
  logic [2:0]  pins_sync;
  logic [1:0]  clk_meta;
  logic        serial_mode;
  prog_word_s  word;
  cmd_state_e  state;
  logic        ctrl_sel;
  logic [31:0] addr;

  // pins are asynchronous; two stages before use
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pins_meta <= '0;
      pins_sync <= '0;
      clk_meta  <= '0;
    end
    else
    begin
      pins_meta <= {test_select_in, prog_enable_in_a, prog_enable_in_b};
      pins_sync <= pins_meta;
      clk_meta  <= {clk_meta[0], main_clock_present_in};
    end
  end

  assign serial_mode = &pins_sync;
  assign serial_mode_out = serial_mode;
  // grounded main clock leaves the device on the rc oscillator
  assign use_rc_osc_out = ~clk_meta[1];

  // serial variant takes its words from the tap side
  assign word = serial_mode ? jtag_word_in : par_word_in;

  function automatic logic is_ctrl_op(input logic [15:0] op);
    is_ctrl_op = (op == `OP_PAGE_WRITE) || (op == `OP_PAGE_WRITE_LK) ||
                 (op == `OP_ERASE_WRITE) || (op == `OP_ERASE_WRITE_LK) ||
                 (op == `OP_FULL_ERASE) || (op == `OP_SET_LOCK) ||
                 (op == `OP_CLEAR_LOCK) || (op == `OP_GET_LOCK) ||
                 (op == `OP_SET_FUSE) || (op == `OP_CLEAR_FUSE) ||
                 (op == `OP_GET_FUSE) || (op == `OP_SET_SECURITY);
  endfunction

  function automatic logic is_phase(input prog_word_s w, input logic [3:0] p);
    is_phase = w.valid && (w.phase == p);
  endfunction

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      state <= ST_IDLE;
    else if (is_phase(word, `PHASE_COMMAND))
    begin
      unique case (word.data)
        `OP_SELECT_CTRL:  state <= ST_SELECT;
        `OP_MEMORY_WRITE: state <= ST_MEMWRITE;
        `OP_GET_VERSION:  state <= ST_VERSION;
        default:          state <= ST_IDLE;
      endcase
    end
    else if (is_phase(word, `PHASE_DATA) && (state != ST_MEMWRITE))
      state <= ST_IDLE;
  end

  // selection only changes on a select data word
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ctrl_sel <= `CTRL_RESET;
    else if ((state == ST_SELECT) && is_phase(word, `PHASE_DATA))
      ctrl_sel <= word.data[0];
  end

  // bytes may be resent mid-stream to redirect writes
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      addr <= `ADDR_RESET;
    else if ((state == ST_MEMWRITE) && word.valid)
    begin
      unique case (word.phase)
        `PHASE_ADDR_BYTE0: addr[7:0]   <= word.data[7:0];
        `PHASE_ADDR_BYTE1: addr[15:8]  <= word.data[7:0];
        `PHASE_ADDR_BYTE2: addr[23:16] <= word.data[7:0];
        `PHASE_ADDR_BYTE3: addr[31:24] <= word.data[7:0];
        `PHASE_DATA:       addr <= addr + `ADDR_STEP;
        default:           addr <= addr;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      mem_write_out <= '0;
    else
    begin
      mem_write_out.valid <= (state == ST_MEMWRITE) && is_phase(word, `PHASE_DATA);
      mem_write_out.addr  <= addr;
      mem_write_out.data  <= word.data;
    end
  end

  // controller ops forwarded as opcode then argument, tagged with selection
  logic [15:0] pending_op;
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pending_op   <= `DATA_ZERO;
      ctrl_cmd_out <= '0;
    end
    else
    begin
      if (is_phase(word, `PHASE_COMMAND))
        pending_op <= word.data;
      // one argument per command; a stray data word must not replay the op
      else if (is_phase(word, `PHASE_DATA))
        pending_op <= `DATA_ZERO;
      ctrl_cmd_out.valid  <= is_phase(word, `PHASE_COMMAND) && is_ctrl_op(word.data);
      ctrl_cmd_out.sel    <= ctrl_sel;
      ctrl_cmd_out.opcode <= word.data;
      ctrl_cmd_out.data   <= `DATA_ZERO;
      if ((state == ST_IDLE) && is_phase(word, `PHASE_DATA) && is_ctrl_op(pending_op))
      begin
        ctrl_cmd_out.valid  <= 1'b1;
        ctrl_cmd_out.opcode <= pending_op;
        ctrl_cmd_out.data   <= word.data;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= `DATA_ZERO;
    end
    else
    begin
      rd_valid_out <= (state == ST_VERSION) && is_phase(word, `PHASE_DATA);
      rd_data_out  <= `PROG_VERSION;
    end
  end

  property p_reset_sel;
    @(posedge clk_in) $fell(rst_in) |-> ctrl_sel == `CTRL_RESET;
  endproperty
  a_reset_sel: assert property (p_reset_sel) else $error("selection not zero after reset");

  property p_select;
    @(posedge clk_in) disable iff (rst_in)
      (state == ST_SELECT) && is_phase(word, `PHASE_DATA) |=> ctrl_sel == $past(word.data[0]);
  endproperty
  a_select: assert property (p_select) else $error("selection not taken from data");

  property p_hold;
    @(posedge clk_in) disable iff (rst_in)
      !((state == ST_SELECT) && is_phase(word, `PHASE_DATA)) |=> $stable(ctrl_sel);
  endproperty
  a_hold: assert property (p_hold) else $error("selection changed without command");

  property p_route;
    @(posedge clk_in) disable iff (rst_in)
      is_phase(word, `PHASE_COMMAND) && is_ctrl_op(word.data) |=> ctrl_cmd_out.valid
        && ctrl_cmd_out.sel == $past(ctrl_sel);
  endproperty
  a_route: assert property (p_route) else $error("controller op misrouted");

  property p_incr;
    @(posedge clk_in) disable iff (rst_in)
      (state == ST_MEMWRITE) && is_phase(word, `PHASE_DATA) |=> addr == $past(addr) + `ADDR_STEP;
  endproperty
  a_incr: assert property (p_incr) else $error("address did not advance");

  property p_store;
    @(posedge clk_in) disable iff (rst_in)
      (state == ST_MEMWRITE) && is_phase(word, `PHASE_DATA) |=> mem_write_out.valid
        && mem_write_out.addr == $past(addr);
  endproperty
  a_store: assert property (p_store) else $error("write not issued at address");

  property p_version;
    @(posedge clk_in) disable iff (rst_in)
      (state == ST_VERSION) && is_phase(word, `PHASE_DATA) |=> rd_valid_out
        && rd_data_out == `PROG_VERSION;
  endproperty
  a_version: assert property (p_version) else $error("version not returned");

  property p_serial;
    @(posedge clk_in) disable iff (rst_in)
      serial_mode && !jtag_word_in.valid |=> !ctrl_cmd_out.valid && !mem_write_out.valid
        && !rd_valid_out;
  endproperty
  a_serial: assert property (p_serial) else $error("stray output in serial mode");

  property p_osc;
    @(posedge clk_in) disable iff (rst_in)
      !main_clock_present_in [*3] |-> use_rc_osc_out;
  endproperty
  a_osc: assert property (p_osc) else $error("rc oscillator not used");

endmodule

/* File: verif/flash_programmer_model.sv */
`timescale 1ns/1ps
`include "flash_prog_params.svh"
module flash_programmer_model
  import flash_prog_pkg::*;
(
  input  wire logic clk_in,
  output prog_word_s word_out
);
  initial word_out = '0;
  // idle word carries flipped fields so stale data never passes for a word
  task automatic send(input logic [3:0] ph, input logic [15:0] d);
    @(posedge clk_in);
    #1 word_out = '{1'b1, ph, d};
    @(posedge clk_in);
    #1 word_out = '{1'b0, ~ph, ~d};
  endtask
  task automatic send_addr(input logic [31:0] a);
    for (int i = 0; i < 4; i++)
      send(`PHASE_ADDR_BYTE0 + 4'(i), {8'h00, a[8*i +: 8]});
  endtask
endmodule

/* File: verif/flash_prog_cmd_extensions_tb.sv */
`timescale 1ns/1ps
`include "flash_prog_params.svh"
module flash_prog_cmd_extensions_tb;
  import flash_prog_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [2:0]  pins   = 3'h0;
  logic        clk_ok = 1'b0;
  prog_word_s  par_w;
  prog_word_s  tap_w;
  ctrl_cmd_s   cc;
  mem_write_s  mw;
  logic        rd_v;
  logic [15:0] rd_d;
  logic        ser;
  logic        rc;
  int          fail_count = 0;
  int          tests_run = 0;
  always #4 clk_in = ~clk_in;
  flash_programmer_model par_prog (.clk_in(clk_in), .word_out(par_w));
  flash_programmer_model tap_prog (.clk_in(clk_in), .word_out(tap_w));
  flash_prog_cmd_ext dut
  (
    .clk_in(clk_in), .rst_in(rst_in), .par_word_in(par_w), .jtag_word_in(tap_w),
    .test_select_in(pins[2]), .prog_enable_in_a(pins[1]), .prog_enable_in_b(pins[0]),
    .main_clock_present_in(clk_ok), .ctrl_cmd_out(cc), .mem_write_out(mw),
    .rd_valid_out(rd_v), .rd_data_out(rd_d), .serial_mode_out(ser), .use_rc_osc_out(rc)
  );
  task automatic check(input logic [48:0] seen, input logic [48:0] exp, input string m);
    tests_run++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: %s", $time, m);
      fail_count++;
    end
  endtask
  task automatic print_verdict;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic ctrl_op(input logic [15:0] op, input logic s, input string m);
    par_prog.send(`PHASE_COMMAND, op);
    check(49'(cc), 49'({1'b1, s, op, `DATA_ZERO}), m);
  endtask
  task automatic test_default;
    check(49'(rc), 49'(1), "rc osc");
    ctrl_op(`OP_FULL_ERASE, 1'b0, "default ctrl");
    par_prog.send(`PHASE_DATA, 16'h00a5);
    check(49'(cc), 49'({2'b10, `OP_FULL_ERASE, 16'h00a5}), "erase arg");
    par_prog.send(`PHASE_DATA, 16'h00a5);
    check(49'(cc.valid), 49'(0), "stray arg ignored");
    $display("done default");
  endtask
  task automatic test_select;
    logic [15:0] ops [11] = '{`OP_PAGE_WRITE, `OP_PAGE_WRITE_LK, `OP_ERASE_WRITE,
      `OP_ERASE_WRITE_LK, `OP_FULL_ERASE, `OP_SET_LOCK, `OP_CLEAR_LOCK, `OP_GET_LOCK,
      `OP_SET_FUSE, `OP_CLEAR_FUSE, `OP_GET_FUSE};
    for (int s = 0; s < 2; s++)
    begin
      par_prog.send(`PHASE_COMMAND, `OP_SELECT_CTRL);
      par_prog.send(`PHASE_DATA, 16'(s));
      foreach (ops[i])
        ctrl_op(ops[i], 1'(s), "routed op");
    end
    $display("done select");
  endtask
  task automatic test_memwrite;
    logic [31:0] base [2] = '{32'hf00d_1234, 32'h2000_0ff8};
    par_prog.send(`PHASE_COMMAND, `OP_MEMORY_WRITE);
    foreach (base[j])
    begin
      par_prog.send_addr(base[j]);
      for (int i = 0; i < 3; i++)
      begin
        par_prog.send(`PHASE_DATA, 16'h5a00 + 16'(i));
        check(49'(mw), {1'b1, base[j] + `ADDR_STEP * 32'(i), 16'h5a00 + 16'(i)}, "mem");
      end
    end
    $display("done memwrite");
  endtask
  task automatic test_version_hold;
    par_prog.send(`PHASE_COMMAND, `OP_GET_VERSION);
    par_prog.send(`PHASE_DATA, 16'hffff);
    check(49'({rd_v, rd_d}), 49'({1'b1, `PROG_VERSION}), "version");
    ctrl_op(`OP_FULL_ERASE, 1'b1, "sel kept");
    par_prog.send(`PHASE_COMMAND, `OP_SELECT_CTRL);
    par_prog.send(`PHASE_DATA, 16'h0000);
    ctrl_op(`OP_SET_SECURITY, 1'b0, "security on ctrl 0");
    $display("done version");
  endtask
  task automatic test_serial_clock;
    pins = 3'h7;
    clk_ok = 1'b1;
    repeat (4) @(posedge clk_in);
    #1 check(49'({ser, rc}), 49'(2), "serial on, rc off");
    par_prog.send(`PHASE_COMMAND, `OP_FULL_ERASE);
    check(49'(cc.valid), 49'(0), "par ignored");
    tap_prog.send(`PHASE_COMMAND, `OP_SET_LOCK);
    check(49'(cc), 49'({2'b10, `OP_SET_LOCK, `DATA_ZERO}), "tap op");
    pins = 3'h3;
    clk_ok = 1'b0;
    repeat (4) @(posedge clk_in);
    #1 check(49'({ser, rc}), 49'(1), "serial off, rc on");
    $display("done serial");
  endtask
  initial
  begin
    #200000;
    fail_count++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge clk_in);
    #1 rst_in = 1'b0;
    test_default();
    test_select();
    test_memwrite();
    test_version_hold();
    test_serial_clock();
    print_verdict();
  end
endmodule
